// ### common/fps_pkg.sv
// constants, carriers and states of the flash program/erase sequencer
// assumes a 125 MHz system clock and a 32-bit flash data path
package fps_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TW = 20;
    localparam int unsigned T_SWE_NS = 10000;
    localparam int unsigned T_PSU_NS = 50000;
    localparam int unsigned T_PROG_NS = 200000;
    localparam int unsigned T_HOLD_NS = 10000;
    localparam int unsigned T_PV_NS = 4000;
    localparam int unsigned T_DUMMY_NS = 2000;
    localparam int unsigned T_ESU_NS = 200000;
    localparam int unsigned T_ERASE_NS = 5000000;
    localparam int unsigned T_EV_NS = 20000;
    localparam int unsigned T_EV_OFF_NS = 5000;
    localparam logic [TW-1:0] C_SWE = TW'((T_SWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] C_PSU = TW'((T_PSU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] C_PROG = TW'((T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] C_HOLD = TW'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] C_PV = TW'((T_PV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] C_DUMMY = TW'((T_DUMMY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] C_ESU = TW'((T_ESU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] C_ERASE = TW'((T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] C_EV = TW'((T_EV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] C_EV_OFF = TW'((T_EV_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // limits and data
    localparam logic [9:0] PROG_MAX_ITER = 10'h3e8;
    localparam logic [9:0] ERASE_MAX_ITER = 10'h03c;
    localparam logic [2:0] UNIT_LAST = 3'h7;
    localparam logic [31:0] DUMMY_WORD = 32'hffffffff;
    localparam logic [31:0] ERASED_WORD = 32'hffffffff;

    // ==========================================================
    // register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_END = 8'h0c;
    localparam logic [7:0] REG_BLOCK = 8'h10;
    localparam logic [2:0] REG_DATA_PAGE = 3'h1;
    localparam int unsigned CTRL_PROG = 0;
    localparam int unsigned CTRL_ERASE = 1;
    localparam int unsigned CTRL_UPM = 2;
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_PASS = 1;
    localparam int unsigned ST_PFAIL = 2;
    localparam int unsigned ST_EFAIL = 3;
    localparam int unsigned ST_UPM = 4;
    localparam int unsigned ST_REFUSED = 5;
    localparam int unsigned ST_ITER_LSB = 16;

    // ==========================================================
    // carriers and states
    typedef struct packed {
        logic software_write_enable;
        logic psu;
        logic pulse;
        logic pv;
        logic esu;
        logic erase;
        logic ev;
        logic wdt;
        logic [7:0] ebs;
    } fps_flash_ctl_s;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SWE_WAIT, ST_WRITE, ST_SETUP, ST_PULSE, ST_PULSE_OFF,
        ST_SETUP_OFF, ST_VER_ON, ST_DUMMY, ST_DUMMY_WAIT, ST_READ, ST_CMP,
        ST_VER_OFF
    } fps_state_e;

endpackage

// ### design/fps_wait_timer.sv
// down-counter timing the waits between control bit changes
// assumes load_i is a one-cycle pulse and counts are nonzero
`timescale 1ns/1ps
module fps_wait_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [fps_pkg::TW-1:0] count_i,
    output logic done_o
);

    logic [fps_pkg::TW-1:0] cnt;

    // done is held off in the load cycle so a stale zero never ends a wait
    assign done_o = (cnt == '0) && !load_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (load_i) begin
            cnt <= count_i;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

endmodule

// ### design/fps_wb_slave.sv
// classic wishbone slave front end for the sequencer registers
// assumes read data is decoded combinationally from wb_adr_i
`timescale 1ns/1ps
module fps_wb_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] rdat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic wr_o,
    output logic [7:0] adr_o,
    output logic [31:0] wdat_o,
    output logic [3:0] sel_o
);

    // one wait state; ack drops the cycle after it was given
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            wr_o <= 1'b0;
            adr_o <= 8'h00;
            wdat_o <= 32'h00000000;
            sel_o <= 4'h0;
        end else begin
            wb_ack_o <= req;
            wr_o <= req && wb_we_i;
            if (req) begin
                adr_o <= wb_adr_i;
                wdat_o <= wb_dat_i;
                sel_o <= wb_sel_i;
                wb_dat_o <= wb_we_i ? 32'h00000000 : rdat_i;
            end
        end
    end

endmodule

// ### design/fps_seq.sv
// host-side sequencer driving flash program and erase control bits
// assumes fl_rdata_i is valid the cycle after fl_re_o and that the
// flash accepts a write on each cycle fl_we_o is high
`timescale 1ns/1ps

module fps_seq #(
    parameter logic [fps_pkg::TW-1:0] PSU_CYC = fps_pkg::C_PSU,
    parameter logic [fps_pkg::TW-1:0] PROG_CYC = fps_pkg::C_PROG,
    parameter logic [fps_pkg::TW-1:0] ESU_CYC = fps_pkg::C_ESU,
    parameter logic [fps_pkg::TW-1:0] ERASE_CYC = fps_pkg::C_ERASE
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output fps_pkg::fps_flash_ctl_s flash_ctl_o,
    output logic [31:0] fl_addr_o,
    output logic [31:0] fl_wdata_o,
    output logic fl_we_o,
    output logic fl_re_o,
    input wire logic [31:0] fl_rdata_i,
    output logic user_prog_mode_o
);

    // ==========================================================
    // functions
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic one_hot(input logic [7:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int b = 0; b < 8; b++) begin
            c = c + {3'h0, v[b]};
        end
        return c == 4'h1;
    endfunction

    // ==========================================================
    // state
    fps_pkg::fps_state_e state;
    logic is_erase;
    logic [9:0] iter;
    logic mism;
    logic [2:0] widx;
    logic [31:0] vaddr;
    logic [31:0] want [0:7];
    logic [31:0] reprog [0:7];
    logic [31:0] base_addr;
    logic [31:0] end_addr;
    logic [7:0] block_sel;
    logic pass_flag;
    logic prog_fail;
    logic erase_fail;
    logic refused;
    logic tmr_load;
    logic [fps_pkg::TW-1:0] tmr_count;
    logic tmr_done;
    logic reg_wr;
    logic [7:0] reg_adr;
    logic [31:0] reg_wdat;
    logic [3:0] reg_sel;
    logic [31:0] rdat;
    logic [31:0] status_word;

    // ==========================================================
    // bus front end and wait timer
    fps_wb_slave u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .rdat_i(rdat),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .wr_o(reg_wr),
        .adr_o(reg_adr),
        .wdat_o(reg_wdat),
        .sel_o(reg_sel)
    );

    fps_wait_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .done_o(tmr_done)
    );

    // ==========================================================
    // decode
    wire idle = state == fps_pkg::ST_IDLE;
    wire wr_ok = reg_wr && idle;
    wire wr_ctrl = wr_ok && reg_adr == fps_pkg::REG_CTRL;
    wire req_prog = reg_wdat[fps_pkg::CTRL_PROG];
    wire req_erase = reg_wdat[fps_pkg::CTRL_ERASE];
    wire start_prog = wr_ctrl && req_prog && user_prog_mode_o;
    wire start_erase = wr_ctrl && req_erase && !req_prog && user_prog_mode_o && one_hot(block_sel);
    wire refuse = reg_wr && reg_adr == fps_pkg::REG_CTRL && (req_prog || req_erase) && !start_prog && !start_erase;
    wire data_rd = wb_adr_i[7:5] == fps_pkg::REG_DATA_PAGE;
    wire data_wr = wr_ok && reg_adr[7:5] == fps_pkg::REG_DATA_PAGE;
    wire verify_ok = is_erase ? fl_rdata_i == fps_pkg::ERASED_WORD : fl_rdata_i == want[widx];
    wire last_addr = is_erase ? vaddr >= end_addr : widx == fps_pkg::UNIT_LAST;
    wire limit_hit = is_erase ? iter >= fps_pkg::ERASE_MAX_ITER : iter >= fps_pkg::PROG_MAX_ITER;
    wire [31:0] reprog_word = want[widx] | ~fl_rdata_i;
    wire [fps_pkg::TW-1:0] setup_cyc = is_erase ? ESU_CYC : PSU_CYC;
    wire [fps_pkg::TW-1:0] pulse_cyc = is_erase ? ERASE_CYC : PROG_CYC;
    wire [fps_pkg::TW-1:0] ver_cyc = is_erase ? fps_pkg::C_EV : fps_pkg::C_PV;
    wire [fps_pkg::TW-1:0] ver_off_cyc = is_erase ? fps_pkg::C_EV_OFF : fps_pkg::C_PV;

    always_comb begin
        status_word = 32'h00000000;
        status_word[fps_pkg::ST_BUSY] = !idle;
        status_word[fps_pkg::ST_PASS] = pass_flag;
        status_word[fps_pkg::ST_PFAIL] = prog_fail;
        status_word[fps_pkg::ST_EFAIL] = erase_fail;
        status_word[fps_pkg::ST_UPM] = user_prog_mode_o;
        status_word[fps_pkg::ST_REFUSED] = refused;
        status_word[fps_pkg::ST_ITER_LSB +: 10] = iter;
    end

    assign rdat = data_rd ? want[wb_adr_i[4:2]] :
                  wb_adr_i == fps_pkg::REG_CTRL ? {29'h0, user_prog_mode_o, 2'h0} :
                  wb_adr_i == fps_pkg::REG_STATUS ? status_word :
                  wb_adr_i == fps_pkg::REG_ADDR ? base_addr :
                  wb_adr_i == fps_pkg::REG_END ? end_addr :
                  wb_adr_i == fps_pkg::REG_BLOCK ? {24'h0, block_sel} : 32'h00000000;

    // ==========================================================
    // software registers, frozen while a sequence runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_addr <= 32'h00000000;
            end_addr <= 32'h00000000;
            block_sel <= 8'h00;
            user_prog_mode_o <= 1'b0;
        end else begin
            if (wr_ok && reg_adr == fps_pkg::REG_ADDR) begin
                base_addr <= merge(base_addr, reg_wdat, reg_sel);
            end
            if (wr_ok && reg_adr == fps_pkg::REG_END) begin
                end_addr <= merge(end_addr, reg_wdat, reg_sel);
            end
            if (wr_ok && reg_adr == fps_pkg::REG_BLOCK && reg_sel[0]) begin
                block_sel <= reg_wdat[7:0];
            end
            // a start write leaves the mode alone so it cannot flip as the operation begins
            if (wr_ctrl && reg_sel[0] && !start_prog && !start_erase) begin
                user_prog_mode_o <= reg_wdat[fps_pkg::CTRL_UPM];
            end
        end
    end

    for (genvar g = 0; g < 8; g++) begin : g_data
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                want[g] <= 32'h00000000;
            end else if (data_wr && reg_adr[4:2] == 3'(g)) begin
                want[g] <= merge(want[g], reg_wdat, reg_sel);
            end
        end
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= fps_pkg::ST_IDLE;
            flash_ctl_o <= '0;
            fl_addr_o <= 32'h00000000;
            fl_wdata_o <= 32'h00000000;
            fl_we_o <= 1'b0;
            fl_re_o <= 1'b0;
            tmr_load <= 1'b0;
            tmr_count <= '0;
            is_erase <= 1'b0;
            iter <= 10'h000;
            mism <= 1'b0;
            widx <= 3'h0;
            vaddr <= 32'h00000000;
            pass_flag <= 1'b0;
            prog_fail <= 1'b0;
            erase_fail <= 1'b0;
            refused <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                reprog[i] <= 32'h00000000;
            end
        end else begin
            fl_we_o <= 1'b0;
            fl_re_o <= 1'b0;
            tmr_load <= 1'b0;
            if (refuse) begin
                refused <= 1'b1;
            end
            case (state)
                fps_pkg::ST_IDLE: begin
                    if (start_prog || start_erase) begin
                        is_erase <= start_erase;
                        pass_flag <= 1'b0;
                        prog_fail <= 1'b0;
                        erase_fail <= 1'b0;
                        refused <= 1'b0;
                        iter <= 10'h001;
                        flash_ctl_o.software_write_enable <= 1'b1;
                        flash_ctl_o.ebs <= start_erase ? block_sel : 8'h00;
                        tmr_count <= fps_pkg::C_SWE;
                        tmr_load <= 1'b1;
                        for (int i = 0; i < 8; i++) begin
                            reprog[i] <= want[i];
                        end
                        state <= fps_pkg::ST_SWE_WAIT;
                    end
                end
                fps_pkg::ST_SWE_WAIT: begin
                    if (tmr_done && is_erase) begin
                        flash_ctl_o.wdt <= 1'b1;
                        flash_ctl_o.esu <= 1'b1;
                        tmr_count <= setup_cyc;
                        tmr_load <= 1'b1;
                        state <= fps_pkg::ST_SETUP;
                    end else if (tmr_done) begin
                        widx <= 3'h0;
                        vaddr <= base_addr;
                        state <= fps_pkg::ST_WRITE;
                    end
                end
                fps_pkg::ST_WRITE: begin
                    fl_we_o <= 1'b1;
                    fl_addr_o <= vaddr;
                    fl_wdata_o <= reprog[widx];
                    widx <= widx + 3'h1;
                    vaddr <= vaddr + 32'h00000004;
                    if (widx == fps_pkg::UNIT_LAST) begin
                        flash_ctl_o.wdt <= 1'b1;
                        flash_ctl_o.psu <= 1'b1;
                        tmr_count <= setup_cyc;
                        tmr_load <= 1'b1;
                        state <= fps_pkg::ST_SETUP;
                    end
                end
                fps_pkg::ST_SETUP: begin
                    if (tmr_done) begin
                        flash_ctl_o.pulse <= !is_erase;
                        flash_ctl_o.erase <= is_erase;
                        tmr_count <= pulse_cyc;
                        tmr_load <= 1'b1;
                        state <= fps_pkg::ST_PULSE;
                    end
                end
                fps_pkg::ST_PULSE: begin
                    if (tmr_done) begin
                        flash_ctl_o.pulse <= 1'b0;
                        flash_ctl_o.erase <= 1'b0;
                        tmr_count <= fps_pkg::C_HOLD;
                        tmr_load <= 1'b1;
                        state <= fps_pkg::ST_PULSE_OFF;
                    end
                end
                fps_pkg::ST_PULSE_OFF: begin
                    if (tmr_done) begin
                        flash_ctl_o.psu <= 1'b0;
                        flash_ctl_o.esu <= 1'b0;
                        tmr_count <= fps_pkg::C_HOLD;
                        tmr_load <= 1'b1;
                        state <= fps_pkg::ST_SETUP_OFF;
                    end
                end
                fps_pkg::ST_SETUP_OFF: begin
                    if (tmr_done) begin
                        flash_ctl_o.wdt <= 1'b0;
                        flash_ctl_o.pv <= !is_erase;
                        flash_ctl_o.ev <= is_erase;
                        iter <= iter + 10'h001;
                        widx <= 3'h0;
                        vaddr <= base_addr;
                        mism <= 1'b0;
                        tmr_count <= ver_cyc;
                        tmr_load <= 1'b1;
                        state <= fps_pkg::ST_VER_ON;
                    end
                end
                fps_pkg::ST_VER_ON: begin
                    if (tmr_done) begin
                        state <= fps_pkg::ST_DUMMY;
                    end
                end
                fps_pkg::ST_DUMMY: begin
                    fl_we_o <= 1'b1;
                    fl_addr_o <= vaddr;
                    fl_wdata_o <= fps_pkg::DUMMY_WORD;
                    tmr_count <= fps_pkg::C_DUMMY;
                    tmr_load <= 1'b1;
                    state <= fps_pkg::ST_DUMMY_WAIT;
                end
                fps_pkg::ST_DUMMY_WAIT: begin
                    if (tmr_done) begin
                        fl_re_o <= 1'b1;
                        fl_addr_o <= vaddr;
                        state <= fps_pkg::ST_READ;
                    end
                end
                fps_pkg::ST_READ: begin
                    state <= fps_pkg::ST_CMP;
                end
                fps_pkg::ST_CMP: begin
                    if (!verify_ok) begin
                        mism <= 1'b1;
                    end
                    if (!is_erase) begin
                        reprog[widx] <= reprog_word;
                    end
                    if (last_addr) begin
                        flash_ctl_o.pv <= 1'b0;
                        flash_ctl_o.ev <= 1'b0;
                        tmr_count <= ver_off_cyc;
                        tmr_load <= 1'b1;
                        state <= fps_pkg::ST_VER_OFF;
                    end else begin
                        widx <= widx + 3'h1;
                        vaddr <= vaddr + 32'h00000004;
                        state <= fps_pkg::ST_DUMMY;
                    end
                end
                fps_pkg::ST_VER_OFF: begin
                    if (tmr_done && (!mism || limit_hit)) begin
                        flash_ctl_o.software_write_enable <= 1'b0;
                        flash_ctl_o.ebs <= 8'h00;
                        pass_flag <= !mism;
                        prog_fail <= mism && !is_erase;
                        erase_fail <= mism && is_erase;
                        state <= fps_pkg::ST_IDLE;
                    end else if (tmr_done && is_erase) begin
                        flash_ctl_o.wdt <= 1'b1;
                        flash_ctl_o.esu <= 1'b1;
                        tmr_count <= setup_cyc;
                        tmr_load <= 1'b1;
                        state <= fps_pkg::ST_SETUP;
                    end else if (tmr_done) begin
                        widx <= 3'h0;
                        vaddr <= base_addr;
                        state <= fps_pkg::ST_WRITE;
                    end
                end
                default: begin
                    state <= fps_pkg::ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ### verification/fps_seq_monitor.sv
// port assertions for the sequencer
// assumes a bind into fps_seq
`timescale 1ns/1ps
module fps_seq_monitor #(
    parameter int PSU_CYC = 1,
    parameter int PROG_CYC = 1,
    parameter int ESU_CYC = 1,
    parameter int ERASE_CYC = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_ack_o,
    input wire fps_pkg::fps_flash_ctl_s flash_ctl_o,
    input wire logic user_prog_mode_o
);
    // ==========
    // checks
    fps_pkg::fps_flash_ctl_s c;
    assign c = flash_ctl_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_pon; $rose(c.pulse); endsequence
    sequence s_eon; $rose(c.erase); endsequence
    property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("long ack");
    property p_swe; |c[14:9] |-> c.software_write_enable; endproperty
    a_swe: assert property (p_swe) else $error("no write enable");
    property p_psu; s_pon |-> $past(c.psu, PSU_CYC); endproperty
    a_psu: assert property (p_psu) else $error("short setup");
    property p_pul; $fell(c.pulse) |-> $past(c.pulse, PROG_CYC) && c.psu; endproperty
    a_pul: assert property (p_pul) else $error("short pulse");
    property p_wdt; c.pulse || c.erase |-> c.wdt; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog off");
    property p_blk; c.esu |-> $onehot(c.ebs); endproperty
    a_blk: assert property (p_blk) else $error("block select");
    property p_ver; c.pv || c.ev |-> !c.psu && !c.esu; endproperty
    a_ver: assert property (p_ver) else $error("verify in setup");
    property p_upm; $changed(user_prog_mode_o) |-> !c.software_write_enable; endproperty
    a_upm: assert property (p_upm) else $error("mode change busy");
    property p_esu; s_eon |-> $past(c.esu, ESU_CYC); endproperty
    a_esu: assert property (p_esu) else $error("short erase setup");
    property p_ers; $fell(c.erase) |-> $past(c.erase, ERASE_CYC) && c.esu; endproperty
    a_ers: assert property (p_ers) else $error("short erase pulse");
    property p_rep; $rose(c.psu) |-> !$past(c.pv, fps_pkg::C_PV); endproperty
    a_rep: assert property (p_rep) else $error("reprogram too soon");
    property p_wait; $rose(c.psu) || $rose(c.esu) |-> $past(c.software_write_enable, fps_pkg::C_SWE); endproperty
    a_wait: assert property (p_wait) else $error("write enable wait short");
endmodule
bind fps_seq fps_seq_monitor #(.PSU_CYC(PSU_CYC), .PROG_CYC(PROG_CYC), .ESU_CYC(ESU_CYC),
    .ERASE_CYC(ERASE_CYC)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
    .wb_ack_o(wb_ack_o), .flash_ctl_o(flash_ctl_o), .user_prog_mode_o(user_prog_mode_o));

// ### verification/fps_flash_model.sv
// flash array model for the sequencer bench
// assumes word index in address bits 4:2
`timescale 1ns/1ps
module fps_flash_model (
    input wire logic clk_i,
    input wire fps_pkg::fps_flash_ctl_s ctl_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] wd_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [31:0] rd_o
);
    logic [7:0][31:0] arr = '1;
    logic [7:0][31:0] lat;
    initial rd_o = 0;
    always @(posedge clk_i) begin
        if (we_i && !ctl_i.pv && !ctl_i.ev) lat[adr_i[4:2]] <= wd_i;
        if (ctl_i.pulse) arr <= arr & lat;
        if (ctl_i.erase && $onehot(ctl_i.ebs)) arr <= '1;
        rd_o <= re_i ? arr[adr_i[4:2]] : ~rd_o;
    end
endmodule

// ### verification/test_fps_seq.sv
// bench for the flash sequencer
// assumes the model and bound monitor
`timescale 1ns/1ps
module test_fps_seq;
    logic clk_i = 0, rst_i = 1, rq = 0, we = 0, ack, fwe, fre, upm;
    logic [7:0] a = 0;
    logic [31:0] d = 0, rd, fa, fw, fr, st;
    fps_pkg::fps_flash_ctl_s ctl;
    int n_errors = 0, cmp_count = 0, n_cyc = 0;
    fps_seq #(.PSU_CYC(20'd20), .PROG_CYC(20'd20), .ESU_CYC(20'd20), .ERASE_CYC(20'd20)) dut (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(rq), .wb_stb_i(rq), .wb_we_i(we), .wb_adr_i(a), .wb_dat_i(d), .wb_sel_i(4'hf),
        .wb_ack_o(ack), .wb_dat_o(rd), .flash_ctl_o(ctl), .fl_addr_o(fa), .fl_wdata_o(fw), .fl_we_o(fwe),
        .fl_re_o(fre), .fl_rdata_i(fr), .user_prog_mode_o(upm));
    fps_flash_model pm (.clk_i(clk_i), .ctl_i(ctl), .adr_i(fa), .wd_i(fw), .we_i(fwe), .re_i(fre), .rd_o(fr));
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dd);
        @(posedge clk_i);
        rq <= 1;
        we <= w;
        a <= ad;
        d <= dd;
        do @(posedge clk_i); while (ack !== 1'b1);
        st = rd;
        rq <= 0;
    endtask
    task automatic wt();
        do wb(0, fps_pkg::REG_STATUS, 0); while (st[0] !== 1'b0);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 60000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        wb(0, 8'h40, 0);
        chk(st, 0);
        wb(1, fps_pkg::REG_CTRL, 1);
        wt();
        chk(st, 32'h20);
        wb(1, fps_pkg::REG_CTRL, 4);
        for (int i = 0; i < 8; i++) wb(1, 8'h20 + 8'(4 * i), 32'h0f0f0f00 | i);
        wb(1, fps_pkg::REG_CTRL, 5);
        wb(1, fps_pkg::REG_CTRL, 1);
        wt();
        chk(st, 32'h00020032);
        for (int i = 0; i < 8; i++) chk(pm.arr[i], 32'h0f0f0f00 | i);
        $display("program test done");
        wb(1, fps_pkg::REG_BLOCK, 3);
        wb(1, fps_pkg::REG_CTRL, 6);
        wt();
        chk(st[5], 1);
        wb(1, fps_pkg::REG_BLOCK, 4);
        wb(1, fps_pkg::REG_END, 32'h1c);
        wb(1, fps_pkg::REG_CTRL, 6);
        wt();
        chk(st, 32'h00020012);
        for (int i = 0; i < 8; i++) chk(pm.arr[i], '1);
        $display("erase test done");
        tally_and_finish();
    end
endmodule
